// ---- logic/edp_pkg.sv ----
// package of constants for the eight-bit dual-function port
package edp_pkg;
    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam logic [3:0] EDP_ADDR_LATCH = 4'h0;
    localparam logic [3:0] EDP_ADDR_DIR = 4'h4;
    localparam logic [3:0] EDP_ADDR_PULSE = 4'h8;
    localparam logic [3:0] EDP_ADDR_FUNC = 4'hC;
    localparam logic [3:0] EDP_ADDR_PULLUP = 4'h0;
    localparam logic [1:0] EDP_PAGE_MAIN = 2'h0;
    localparam logic [1:0] EDP_PAGE_OPT = 2'h1;
    // ****************************************
    // widths, fields, resets
    // ****************************************
    localparam int EDP_W = 8;
    localparam int EDP_BIT_PA = 0;
    localparam int EDP_BIT_PB = 1;
    localparam int EDP_BIT_SCK = 2;
    localparam int EDP_BIT_RX = 3;
    localparam int EDP_BIT_TX = 4;
    localparam int EDP_BIT_PUO = 1;
    localparam logic [7:0] EDP_DIR_RST = 8'hFF;
    localparam logic [7:0] EDP_ZERO8 = 8'h00;
    localparam logic [1:0] EDP_PULSE_RST = 2'h0;
    localparam logic [2:0] EDP_FUNC_RST = 3'h0;
    localparam logic [31:0] EDP_UNMAPPED = 32'h0000_0000;
endpackage

// ---- logic/edp_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module edp_pin_sync (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] pin_in,
    output logic [7:0] level_out
);
    logic [7:0] s1_r;
    logic [7:0] s2_r;
    logic [7:0] s3_r;
    logic [7:0] level_r;

    // first stage feeds only the second; reset level is high as pull-ups idle
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s1_r <= edp_pkg::EDP_DIR_RST;
            s2_r <= edp_pkg::EDP_DIR_RST;
            s3_r <= edp_pkg::EDP_DIR_RST;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a bit changes only once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < edp_pkg::EDP_W; i++) begin : g_flt
            always_ff @(posedge clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    level_r[i] <= 1'b1;
                end else if (s2_r[i] == s3_r[i]) begin
                    level_r[i] <= s3_r[i];
                end
            end
        end
    endgenerate

    assign level_out = level_r;
endmodule

// ---- logic/edp_port.sv ----
// eight-bit dual-function port with avalon-mm register slave
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module edp_port (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // avalon-mm slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [1:0] avs_page_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // internal peripheral signals
    input wire logic pulse_out_a_in,
    input wire logic pulse_out_b_in,
    input wire logic serial_clk_o_in,
    input wire logic serial_clk_oe_in,
    input wire logic serial_tx_out_in,
    output logic serial_clk_i_out,
    output logic serial_rx_in_out,
    // pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_out,
    output logic [7:0] pullup_en_out
);
    // ****************************************
    // registers
    // ****************************************
    logic [7:0] latch_r;
    logic [7:0] dir_reg_r;
    logic [1:0] pulse_ctrl_reg_r;
    logic [2:0] func_select_reg_r;
    logic pullup_enable_this_port_r;
    logic [31:0] rdata_r;
    logic ack_r;
    logic [7:0] level;
    logic [7:0] func_on;
    logic [7:0] func_out;
    logic [7:0] func_drive;
    logic [7:0] port_view;
    logic [7:0] pin_r;
    logic [7:0] oe_r;
    logic [7:0] pu_r;
    logic req;
    logic wr_hit;
    logic sel_latch;
    logic sel_dir;
    logic sel_pulse;
    logic sel_func;
    logic sel_pu;

    // pin levels reach software only through the synchroniser
    edp_pin_sync u_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .pin_in(pin_in),
        .level_out(level)
    );

    // ****************************************
    // bus decode
    // ****************************************
    // one wait cycle per access so read data come from a flop
    assign req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req & ~ack_r;
    assign wr_hit = avs_write_in & ack_r & avs_byteenable_in[0];
    assign sel_latch = (avs_page_in == edp_pkg::EDP_PAGE_MAIN)
                       && (avs_address_in == edp_pkg::EDP_ADDR_LATCH);
    assign sel_dir = (avs_page_in == edp_pkg::EDP_PAGE_MAIN)
                     && (avs_address_in == edp_pkg::EDP_ADDR_DIR);
    assign sel_pulse = (avs_page_in == edp_pkg::EDP_PAGE_MAIN)
                       && (avs_address_in == edp_pkg::EDP_ADDR_PULSE);
    assign sel_func = (avs_page_in == edp_pkg::EDP_PAGE_MAIN)
                      && (avs_address_in == edp_pkg::EDP_ADDR_FUNC);
    assign sel_pu = (avs_page_in == edp_pkg::EDP_PAGE_OPT)
                    && (avs_address_in == edp_pkg::EDP_ADDR_PULLUP);

    // acknowledge pulses high for the edge that completes the access
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // latch takes every write with byte lane 0 enabled, whatever the direction; reset leaves it zero,
    // software must not rely on that value
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            latch_r <= edp_pkg::EDP_ZERO8;
        end else if (wr_hit && sel_latch) begin
            latch_r <= avs_writedata_in[7:0];
        end
    end

    // direction: all inputs out of reset
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dir_reg_r <= edp_pkg::EDP_DIR_RST;
        end else if (wr_hit && sel_dir) begin
            dir_reg_r <= avs_writedata_in[7:0];
        end
    end

    // pulse enables and serial function selects
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pulse_ctrl_reg_r <= edp_pkg::EDP_PULSE_RST;
            func_select_reg_r <= edp_pkg::EDP_FUNC_RST;
        end else begin
            if (wr_hit && sel_pulse) begin
                pulse_ctrl_reg_r <= avs_writedata_in[edp_pkg::EDP_BIT_PB:edp_pkg::EDP_BIT_PA];
            end
            if (wr_hit && sel_func) begin
                func_select_reg_r <= avs_writedata_in[edp_pkg::EDP_BIT_TX:edp_pkg::EDP_BIT_SCK];
            end
        end
    end

    // pull-up option bit for this port
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pullup_enable_this_port_r <= 1'b0;
        end else if (wr_hit && sel_pu) begin
            pullup_enable_this_port_r <= avs_writedata_in[edp_pkg::EDP_BIT_PUO];
        end
    end

    // ****************************************
    // function mux
    // ****************************************
    // bits 5..7 carry no function: func_on stays low there
    always_comb begin
        func_on = edp_pkg::EDP_ZERO8;
        func_on[edp_pkg::EDP_BIT_PA] = pulse_ctrl_reg_r[0];
        func_on[edp_pkg::EDP_BIT_PB] = pulse_ctrl_reg_r[1];
        func_on[edp_pkg::EDP_BIT_SCK] = func_select_reg_r[0];
        func_on[edp_pkg::EDP_BIT_RX] = func_select_reg_r[1];
        func_on[edp_pkg::EDP_BIT_TX] = func_select_reg_r[2];
        func_out = edp_pkg::EDP_ZERO8;
        func_out[edp_pkg::EDP_BIT_PA] = pulse_out_a_in;
        func_out[edp_pkg::EDP_BIT_PB] = pulse_out_b_in;
        func_out[edp_pkg::EDP_BIT_SCK] = serial_clk_o_in;
        func_out[edp_pkg::EDP_BIT_TX] = serial_tx_out_in;
        // receive pin is input only; serial clock drives only as master
        func_drive = edp_pkg::EDP_ZERO8;
        func_drive[edp_pkg::EDP_BIT_PA] = 1'b1;
        func_drive[edp_pkg::EDP_BIT_PB] = 1'b1;
        func_drive[edp_pkg::EDP_BIT_SCK] = serial_clk_oe_in;
        func_drive[edp_pkg::EDP_BIT_TX] = 1'b1;
    end

    // ****************************************
    // per-pin drive, pull-up and read view
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < edp_pkg::EDP_W; i++) begin : g_pin
            // pin drivers registered so pins never glitch on mux changes;
            // costs one cycle from register write to pin
            always_ff @(posedge clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    pin_r[i] <= 1'b0;
                    oe_r[i] <= 1'b0;
                end else if (func_on[i]) begin
                    pin_r[i] <= func_out[i];
                    oe_r[i] <= func_drive[i];
                end else begin
                    pin_r[i] <= latch_r[i];
                    oe_r[i] <= ~dir_reg_r[i];
                end
            end

            // pull-up follows direction bit, also on control outputs
            always_ff @(posedge clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    pu_r[i] <= 1'b0;
                end else begin
                    pu_r[i] <= pullup_enable_this_port_r & dir_reg_r[i];
                end
            end

            // read view: pin level unless a control output with direction 0
            always_comb begin
                if (func_on[i] && func_drive[i] && !dir_reg_r[i]) begin
                    port_view[i] = func_out[i];
                end else if (func_on[i] || dir_reg_r[i]) begin
                    port_view[i] = level[i];
                end else begin
                    // plain output bit: synchronised pin equals latch once settled
                    port_view[i] = level[i];
                end
            end
        end
    endgenerate

    assign pin_out = pin_r;
    assign pin_oe_out = oe_r;
    assign pullup_en_out = pu_r;
    assign serial_clk_i_out = level[edp_pkg::EDP_BIT_SCK];
    assign serial_rx_in_out = level[edp_pkg::EDP_BIT_RX];

    // ****************************************
    // read data
    // ****************************************
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_r <= edp_pkg::EDP_UNMAPPED;
        end else if (avs_read_in && !ack_r) begin
            rdata_r <= edp_pkg::EDP_UNMAPPED;
            if (sel_latch) begin
                rdata_r[7:0] <= port_view;
            end else if (sel_dir) begin
                rdata_r[7:0] <= dir_reg_r;
            end else if (sel_pulse) begin
                rdata_r[edp_pkg::EDP_BIT_PB:edp_pkg::EDP_BIT_PA] <= pulse_ctrl_reg_r;
            end else if (sel_func) begin
                rdata_r[edp_pkg::EDP_BIT_TX:edp_pkg::EDP_BIT_SCK] <= func_select_reg_r;
            end else if (sel_pu) begin
                rdata_r[edp_pkg::EDP_BIT_PUO] <= pullup_enable_this_port_r;
            end
        end
    end

    assign avs_readdata_out = rdata_r;

    // ****************************************
    // checks
    // ****************************************
    // a bit left in plain input mode
    sequence s_dir_in;
        !func_on[7] && dir_reg_r[7];
    endsequence

    // a bus access: request taken with no acknowledge, answer one cycle on
    sequence s_access_start;
        req && !ack_r;
    endsequence

    sequence s_access_done;
        !avs_waitrequest_out;
    endsequence

    // a port read taken at this edge; its data stand one cycle later
    sequence s_port_read;
        avs_read_in && !ack_r && sel_latch;
    endsequence

    // a write to the output latches completing at this edge
    sequence s_latch_write;
        wr_hit && sel_latch;
    endsequence

    // ****************************************
    // pin drive checks
    // ****************************************
    a_input_undriven: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_dir_in |=> !pin_oe_out[7])
        else $error("input bit is driven");
    a_output_latch: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!func_on[6] && !dir_reg_r[6]) |=> (pin_oe_out[6] && pin_out[6] == $past(latch_r[6])))
        else $error("output bit does not show latch");
    a_dir_switch: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(dir_reg_r[5]) |-> ##1 (pin_oe_out[5] && pin_out[5] == $past(latch_r[5])))
        else $error("switch to output did not drive latch");
    a_high_bits_plain: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        1'b1 |=> (pin_oe_out[7:5] == ~$past(dir_reg_r[7:5])
                  && pin_out[7:5] == $past(latch_r[7:5])))
        else $error("plain bit follows a function");
    a_latch_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !(wr_hit && sel_latch) |=> $stable(latch_r))
        else $error("latch changed without a port write");
    a_latch_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_latch_write |=> latch_r == $past(avs_writedata_in[7:0]))
        else $error("port write did not reach all latches");

    // ****************************************
    // function pin checks
    // ****************************************
    a_pulse_a_pin: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        pulse_ctrl_reg_r[0] |=> (pin_oe_out[0] && pin_out[0] == $past(pulse_out_a_in)))
        else $error("pulse a not on bit 0");
    a_pulse_b_pin: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        pulse_ctrl_reg_r[1] |=> (pin_oe_out[1] && pin_out[1] == $past(pulse_out_b_in)))
        else $error("pulse b not on bit 1");
    a_sck_pin: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        func_select_reg_r[0] |=> (pin_oe_out[2] == $past(serial_clk_oe_in)
                                  && pin_out[2] == $past(serial_clk_o_in)))
        else $error("serial clock not on bit 2");
    a_tx_pin: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        func_select_reg_r[2] |=> (pin_oe_out[4] && pin_out[4] == $past(serial_tx_out_in)))
        else $error("transmit not on bit 4");
    a_rx_override: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        func_select_reg_r[1] |=> !pin_oe_out[3])
        else $error("receive pin driven");

    // ****************************************
    // pull-up checks
    // ****************************************
    a_pullup_map: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        1'b1 |=> pullup_en_out == ($past(dir_reg_r) & {8{$past(pullup_enable_this_port_r)}}))
        else $error("pull-up enable mismatch");
    a_pullup_ctrl_out: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (pulse_ctrl_reg_r[0] && dir_reg_r[0] && pullup_enable_this_port_r)
        |=> pullup_en_out[0])
        else $error("pull-up missing on control output");

    // ****************************************
    // read view checks
    // ****************************************
    a_ctrl_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_port_read ##0 (pulse_ctrl_reg_r[1] && !dir_reg_r[1])
        |=> avs_readdata_out[1] == $past(pulse_out_b_in))
        else $error("control output read wrong");
    a_input_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_port_read ##0 dir_reg_r[7] |=> avs_readdata_out[7] == $past(level[7]))
        else $error("input bit read shows latch");
    a_ctrl_pin_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_port_read ##0 (func_select_reg_r[2] && dir_reg_r[4])
        |=> avs_readdata_out[4] == $past(level[4]))
        else $error("control output with direction 1 read wrong");

    // ****************************************
    // bus checks
    // ****************************************
    a_wait_one: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_access_start |=> s_access_done)
        else $error("access not answered in one wait");
    a_read_upper: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (avs_read_in && !avs_waitrequest_out) |-> avs_readdata_out[31:8] == 24'h000000)
        else $error("read data above the port byte not zero");
    a_dir_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_hit && sel_dir) |=> dir_reg_r == $past(avs_writedata_in[7:0]))
        else $error("direction write lost");
    a_be_ignored: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (avs_write_in && ack_r && !avs_byteenable_in[0]) |=> ($stable(dir_reg_r) && $stable(latch_r)))
        else $error("write with lane 0 off changed a register");
endmodule

// ---- verif/edp_pin_model.sv ----
// board-side model of the eight port pins with loads and floating lines
`timescale 1ns/1ps
module edp_pin_model (
    input wire logic clk_in,
    input wire logic [7:0] pin_out_in,
    input wire logic [7:0] pin_oe_in,
    input wire logic [7:0] pullup_en_in,
    input wire logic [7:0] ext_val_in,
    input wire logic [7:0] ext_drv_in,
    output logic [7:0] level_out
);
    // ****************************************
    // pin resolution
    // ****************************************
    logic [7:0] float_r = 8'h55;
    // undriven lines flip every cycle so a stale value can never pass for a level
    always_ff @(posedge clk_in) begin
        float_r <= ~float_r;
    end
    // device drive wins, then board drive, then pull-up, else floating
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_in[i])
                level_out[i] = pin_out_in[i];
            else if (ext_drv_in[i])
                level_out[i] = ext_val_in[i];
            else if (pullup_en_in[i])
                level_out[i] = 1'b1;
            else
                level_out[i] = float_r[i];
        end
    end
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the eight-bit dual-function port
`timescale 1ns/1ps
module testbench;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [1:0] avs_page_in = 2'h0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic pa = 1'b0;
    logic pb = 1'b0;
    logic sck_o = 1'b0;
    logic sck_oe = 1'b0;
    logic tx = 1'b0;
    logic sck_i, rx_o;
    logic [7:0] lvl, pin_out, pin_oe, pull_en;
    logic [7:0] ext_val = 8'h3C;
    logic [7:0] ext_drv = 8'hFF;
    logic [3:0] be = 4'hF;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    // 10 MHz system clock
    always #50 clk_in = ~clk_in;
    edp_port u_edp_port (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(be), .avs_page_in(avs_page_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .pulse_out_a_in(pa), .pulse_out_b_in(pb), .serial_clk_o_in(sck_o),
        .serial_clk_oe_in(sck_oe), .serial_tx_out_in(tx), .serial_clk_i_out(sck_i),
        .serial_rx_in_out(rx_o), .pin_in(lvl), .pin_out(pin_out),
        .pin_oe_out(pin_oe), .pullup_en_out(pull_en));
    edp_pin_model u_edp_pin_model (.clk_in(clk_in), .pin_out_in(pin_out),
        .pin_oe_in(pin_oe), .pullup_en_in(pull_en), .ext_val_in(ext_val),
        .ext_drv_in(ext_drv), .level_out(lvl));
    // ****************************************
    // tasks
    // ****************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one avalon transfer; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [1:0] pg, input logic [3:0] adr,
                       input logic [7:0] wd, output logic [31:0] rd);
        @(posedge clk_in);
        avs_read_in <= !wr;
        avs_write_in <= wr;
        avs_address_in <= adr;
        avs_page_in <= pg;
        avs_writedata_in <= {24'h0, wd};
        // only the bench timeout ends a wait that never completes
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    task automatic wr(input logic [1:0] pg, input logic [3:0] adr, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, pg, adr, d, q);
    endtask
    task automatic rdchk(input logic [1:0] pg, input logic [3:0] adr, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, pg, adr, 8'h00, q);
        chk(q, {24'h0, e});
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // hang guard: far above the fewer than two hundred cycles the sequence needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        tick(1);
        chk({pin_oe, pull_en}, 16'h0000);
        rdchk(2'h0, 4'h4, 8'hFF);
        wr(2'h0, 4'h0, 8'hA5);
        tick(2);
        chk(pin_oe, 8'h00);
        tick(6);
        rdchk(2'h0, 4'h0, 8'h3C);
        ext_drv <= 8'hF0;
        wr(2'h0, 4'h4, 8'hF0);
        tick(2);
        chk({pin_oe, pin_out & pin_oe}, 16'h0F05);
        wr(2'h0, 4'h0, 8'h0A);
        tick(2);
        chk(pin_out & pin_oe, 8'h0A);
        tick(6);
        rdchk(2'h0, 4'h0, 8'h3A);
        wr(2'h1, 4'h0, 8'h02);
        ext_drv <= 8'h00;
        tick(2);
        chk(pull_en, 8'hF0);
        tick(6);
        rdchk(2'h0, 4'h0, 8'hFA);
        // pulse outputs with direction 0 read back the internal signal
        pa <= 1'b1;
        wr(2'h0, 4'h8, 8'h03);
        tick(2);
        chk({pin_oe, pin_out & 8'h03}, 16'h0F01);
        tick(6);
        rdchk(2'h0, 4'h0, 8'hF9);
        pb <= 1'b1;
        wr(2'h0, 4'h4, 8'hF3);
        tick(2);
        chk({pin_oe, pull_en}, 16'h0FF3);
        tick(6);
        rdchk(2'h0, 4'h0, 8'hFB);
        // serial functions: clock driven, receive stays input, transmit driven
        sck_oe <= 1'b1;
        tx <= 1'b1;
        ext_drv <= 8'h08;
        wr(2'h0, 4'h8, 8'h00);
        wr(2'h0, 4'hC, 8'h1C);
        tick(2);
        chk({pin_oe, pin_out & pin_oe}, 16'h1410);
        tick(6);
        chk(rx_o, 1'b1);
        rdchk(2'h0, 4'h0, 8'hFB);
        sck_oe <= 1'b0;
        ext_drv <= 8'h0C;
        tick(6);
        chk({pin_oe, 7'h0, sck_i}, 16'h1001);
        // every function bit set: bits 5 to 7 still follow direction and latch
        wr(2'h0, 4'hC, 8'hFF);
        wr(2'h0, 4'h8, 8'hFF);
        wr(2'h0, 4'h4, 8'h00);
        wr(2'h0, 4'h0, 8'hE0);
        tick(2);
        chk({pin_oe, pin_out & pin_oe}, 16'hF3F3);
        rdchk(2'h0, 4'hC, 8'h1C);
        rdchk(2'h0, 4'h8, 8'h03);
        // a write with lane 0 disabled leaves the direction alone
        be <= 4'hE;
        wr(2'h0, 4'h4, 8'hFF);
        be <= 4'hF;
        rdchk(2'h0, 4'h4, 8'h00);
        wr(2'h0, 4'h4, 8'hE0);
        tick(2);
        chk(pin_oe, 8'h13);
        // unmapped places read zero and ignore writes
        wr(2'h1, 4'h4, 8'hFF);
        rdchk(2'h1, 4'h4, 8'h00);
        rdchk(2'h2, 4'h0, 8'h00);
        // reset in mid-run must drop every driver and pull-up again
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        tick(1);
        chk({pin_oe, pull_en}, 16'h0000);
        rdchk(2'h1, 4'h0, 8'h00);
        rdchk(2'h0, 4'h4, 8'hFF);
        summarize();
    end
endmodule
